// ===== hdl/clge_top.sv
// top of the cycle logic gate evaluator: source pool, eight gates, network outputs
// assumes all inputs are synchronous to clk and configuration is static between strobes
`timescale 1ns/1ps
`include "clge_map.svh"
module clge_top
  import clge_pkg::*;
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // program cycle strobe
  input wire logic cycle_strobe,
  // read-only shift register bits, bit 0 is shift_bit_first, bit 31 shift_bit_last
  input wire logic [`CLGE_SHIFT_N-1:0] shift_bits,
  // navigation keys from the base unit and from the remote display
  input wire logic [`CLGE_CURSOR_N-1:0] cursor_base,
  input wire logic [`CLGE_CURSOR_N-1:0] cursor_remote,
  // operator keys, bit 0 operator_key_one to bit 3 operator_key_four
  input wire logic [`CLGE_FKEY_N-1:0] operator_keys,
  // network inputs
  input wire logic [`CLGE_NET_IN_N-1:0] net_digital_in,
  input wire clge_word_t [`CLGE_NET_AIN_N-1:0] net_analog_in,
  // gate configuration
  input wire clge_sel_t [`CLGE_GATE_N-1:0][`CLGE_GATE_INPUTS-1:0] gate_sel,
  input wire logic [`CLGE_GATE_N-1:0][`CLGE_GATE_INPUTS-1:0] gate_inv,
  // network output routing
  input wire clge_sel_t [`CLGE_NET_OUT_N-1:0] net_out_sel,
  input wire logic [`CLGE_NET_AOUT_N-1:0][`CLGE_AIN_SEL_W-1:0] net_aout_sel,
  // results
  output logic [`CLGE_GATE_N-1:0] gate_q,
  output logic [`CLGE_NET_OUT_N-1:0] net_digital_out,
  output clge_word_t [`CLGE_NET_AOUT_N-1:0] net_analog_out
);
  logic fire;
  logic [`CLGE_POOL_N-1:0] pool;
  logic [`CLGE_NET_OUT_N-1:0] dout_reg;
  logic [`CLGE_NET_OUT_N-1:0] dout_next;
  clge_word_t [`CLGE_NET_AOUT_N-1:0] aout_reg;
  clge_word_t [`CLGE_NET_AOUT_N-1:0] aout_next;

  assign fire = ce & cycle_strobe;

  // source pool; gate results feed back as last cycle's values
  always_comb
  begin
    pool = '0;
    // RL12 permanent high level
    pool[`CLGE_SRC_HI] = 1'b1;
    // RL13 shift bits read only
    pool[`CLGE_SRC_SHIFT_BASE +: `CLGE_SHIFT_N] = shift_bits;
    // RL15 remote keys merge with base
    pool[`CLGE_SRC_CURSOR_BASE +: `CLGE_CURSOR_N] = cursor_base | cursor_remote;
    // RL16 operator keys as inputs
    pool[`CLGE_SRC_FKEY_BASE +: `CLGE_FKEY_N] = operator_keys;
    // RL14 network digital inputs
    pool[`CLGE_SRC_NET_IN_BASE +: `CLGE_NET_IN_N] = net_digital_in;
    pool[`CLGE_SRC_GATE_BASE +: `CLGE_GATE_N] = gate_q;
  end

  // gate g has kind g of the kind enumeration
  genvar g;
  generate
    for (g = 0; g < `CLGE_GATE_N; g++)
    begin : g_gate
      clge_gate_if gif();
      assign gif.sel = gate_sel[g];
      assign gif.inv = gate_inv[g];
      clge_source_mux u_mux (
        .pool(pool),
        .bus(gif.mux)
      );
      clge_gate #(
        .KIND(clge_kind_t'(g))
      ) u_gate (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .strobe(cycle_strobe),
        .bus(gif.gate),
        .q(gate_q[g])
      );
    end
  endgenerate

  // network output routing
  genvar k;
  generate
    for (k = 0; k < `CLGE_NET_OUT_N; k++)
    begin : g_dout
      // RL14 network digital outputs
      assign dout_next[k] = fire ? pool[net_out_sel[k]] : dout_reg[k];
    end
    for (k = 0; k < `CLGE_NET_AOUT_N; k++)
    begin : g_aout
      // RL14 network analog outputs
      assign aout_next[k] = fire ? net_analog_in[net_aout_sel[k]] : aout_reg[k];
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      dout_reg <= '0;
      aout_reg <= '0;
    end
    else if (ce)
    begin
      dout_reg <= dout_next;
      aout_reg <= aout_next;
    end
  end

  assign net_digital_out = dout_reg;
  assign net_analog_out = aout_reg;

  // helper model of the effective gate inputs, read only by the checks below
  function automatic logic pick(input logic [`CLGE_POOL_N-1:0] p, input clge_sel_t s,
                                input logic v, input logic d);
    pick = (s == `CLGE_SRC_OPEN) ? d : (p[s] ^ v);
  endfunction

  logic [`CLGE_GATE_N-1:0][`CLGE_GATE_INPUTS-1:0] chk_eff;
  logic [`CLGE_GATE_INPUTS-1:0] chk_prev_and;
  logic [`CLGE_GATE_INPUTS-1:0] chk_prev_nand;
  logic [`CLGE_GATE_N-1:0] chk_all_open;

  always_comb
  begin
    for (int gi = 0; gi < `CLGE_GATE_N; gi++)
    begin
      chk_all_open[gi] = 1'b1;
      for (int ii = 0; ii < `CLGE_GATE_INPUTS; ii++)
      begin
        chk_eff[gi][ii] = pick(pool, gate_sel[gi][ii], gate_inv[gi][ii], (gi < 4));
        if (gate_sel[gi][ii] != `CLGE_SRC_OPEN)
        begin
          chk_all_open[gi] = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      chk_prev_and <= '0;
      chk_prev_nand <= '0;
    end
    else if (fire)
    begin
      chk_prev_and <= chk_eff[1];
      chk_prev_nand <= chk_eff[3];
    end
  end

  and_result_a: assert property ( // RL1
    @(posedge clk) disable iff (!resetn)
    fire |=> gate_q[0] == (&$past(chk_eff[0])))
    else $error("and gate result wrong");

  and_open_one_a: assert property ( // RL2
    @(posedge clk) disable iff (!resetn)
    (fire && chk_all_open[0] && chk_all_open[2]) |=> gate_q[0] && !gate_q[2])
    else $error("open and or nand input not read as one");

  and_rise_a: assert property ( // RL3
    @(posedge clk) disable iff (!resetn)
    fire |=> gate_q[1] == ((&$past(chk_eff[1])) && !(&$past(chk_prev_and))))
    else $error("rising and result wrong");

  nand_result_a: assert property ( // RL4
    @(posedge clk) disable iff (!resetn)
    fire |=> gate_q[2] == !(&$past(chk_eff[2])))
    else $error("nand gate result wrong");

  nand_fall_a: assert property ( // RL5
    @(posedge clk) disable iff (!resetn)
    fire |=> gate_q[3] == (!(&$past(chk_eff[3])) && (&$past(chk_prev_nand))))
    else $error("falling nand result wrong");

  or_result_a: assert property ( // RL6
    @(posedge clk) disable iff (!resetn)
    fire |=> gate_q[4] == (|$past(chk_eff[4])))
    else $error("or gate result wrong");

  nor_result_a: assert property ( // RL7
    @(posedge clk) disable iff (!resetn)
    fire |=> gate_q[5] == !(|$past(chk_eff[5])))
    else $error("nor gate result wrong");

  or_open_zero_a: assert property ( // RL8
    @(posedge clk) disable iff (!resetn)
    (fire && chk_all_open[4] && chk_all_open[5]) |=> !gate_q[4] && gate_q[5])
    else $error("open or input not read as zero");

  xor_result_a: assert property ( // RL9
    @(posedge clk) disable iff (!resetn)
    fire |=> gate_q[6] == ($past(chk_eff[6][0]) ^ $past(chk_eff[6][1])))
    else $error("xor gate result wrong");

  not_result_a: assert property ( // RL10
    @(posedge clk) disable iff (!resetn)
    fire |=> gate_q[7] == !$past(chk_eff[7][0]))
    else $error("not gate result wrong");

  input_invert_a: assert property ( // RL11
    @(posedge clk) disable iff (!resetn)
    (fire && gate_sel[0][0] == `CLGE_SRC_HI && gate_inv[0][0]) |=> !gate_q[0])
    else $error("inverted high input did not block and");

  const_high_a: assert property ( // RL12
    @(posedge clk) disable iff (!resetn)
    (fire && gate_sel[4][0] == `CLGE_SRC_HI && !gate_inv[4][0]) |=> gate_q[4])
    else $error("constant high did not reach or");

  shift_read_a: assert property ( // RL13
    @(posedge clk) disable iff (!resetn)
    (fire && net_out_sel[0] == `CLGE_SRC_SHIFT_BASE)
      |=> net_digital_out[0] == $past(shift_bits[0]))
    else $error("shift bit not routed");

  analog_route_a: assert property ( // RL14
    @(posedge clk) disable iff (!resetn)
    fire |=> net_analog_out[0] == $past(net_analog_in[net_aout_sel[0]]))
    else $error("analog output routing wrong");

  cursor_merge_a: assert property ( // RL15
    @(posedge clk) disable iff (!resetn)
    (fire && net_out_sel[1] == `CLGE_SRC_CURSOR_BASE && cursor_remote[0])
      |=> net_digital_out[1])
    else $error("remote cursor key lost");

  fkey_route_a: assert property ( // RL16
    @(posedge clk) disable iff (!resetn)
    (fire && net_out_sel[2] == `CLGE_SRC_FKEY_BASE)
      |=> net_digital_out[2] == $past(operator_keys[0]))
    else $error("operator key not routed");

  hold_between_a: assert property ( // RL17
    @(posedge clk) disable iff (!resetn)
    !fire |=> $stable(gate_q) && $stable(net_digital_out) && $stable(net_analog_out))
    else $error("state changed without strobe");

  refused_hold_a: assert property ( // RL17
    @(posedge clk) disable iff (!resetn)
    (cycle_strobe && !ce) |=> $stable(gate_q) && $stable(net_analog_out))
    else $error("strobe taken while enable low");

  rise_no_repeat_a: assert property ( // RL3
    @(posedge clk) disable iff (!resetn)
    (fire && (&chk_prev_and)) |=> !gate_q[1])
    else $error("rising and repeated while inputs held high");

  rise_needs_all_a: assert property ( // RL3
    @(posedge clk) disable iff (!resetn)
    (fire && !(&chk_eff[1])) |=> !gate_q[1])
    else $error("rising and high with a low input");

  fall_needs_prev_a: assert property ( // RL5
    @(posedge clk) disable iff (!resetn)
    (fire && !(&chk_prev_nand)) |=> !gate_q[3])
    else $error("falling nand high without all high before");

  fall_needs_low_a: assert property ( // RL5
    @(posedge clk) disable iff (!resetn)
    (fire && (&chk_eff[3])) |=> !gate_q[3])
    else $error("falling nand high with all inputs high");

  nand_all_high_a: assert property ( // RL4
    @(posedge clk) disable iff (!resetn)
    (fire && (&chk_eff[2])) |=> !gate_q[2])
    else $error("nand not low with all inputs high");

  or_all_low_a: assert property ( // RL6
    @(posedge clk) disable iff (!resetn)
    (fire && !(|chk_eff[4])) |=> !gate_q[4])
    else $error("or high with all inputs low");

  nor_any_high_a: assert property ( // RL7
    @(posedge clk) disable iff (!resetn)
    (fire && (|chk_eff[5])) |=> !gate_q[5])
    else $error("nor high with an input high");

  nand_open_one_a: assert property ( // RL2
    @(posedge clk) disable iff (!resetn)
    (fire && chk_all_open[2]) |=> !gate_q[2])
    else $error("open nand inputs not read as one");

  rise_open_one_a: assert property ( // RL2
    @(posedge clk) disable iff (!resetn)
    (fire && chk_all_open[1]) |=> gate_q[1] == !(&$past(chk_prev_and)))
    else $error("open rising and inputs not read as one");

  fall_open_one_a: assert property ( // RL2
    @(posedge clk) disable iff (!resetn)
    (fire && chk_all_open[3]) |=> !gate_q[3])
    else $error("open falling nand inputs not read as one");

  xor_open_zero_a: assert property ( // RL8
    @(posedge clk) disable iff (!resetn)
    (fire && chk_all_open[6]) |=> !gate_q[6])
    else $error("open xor inputs not read as zero");

  not_open_high_a: assert property ( // RL10
    @(posedge clk) disable iff (!resetn)
    (fire && chk_all_open[7]) |=> gate_q[7])
    else $error("open inverter input not read as zero");

  const_low_a: assert property ( // RL12
    @(posedge clk) disable iff (!resetn)
    (fire && gate_sel[0][0] == `CLGE_SRC_LO && !gate_inv[0][0]) |=> !gate_q[0])
    else $error("constant low did not block and");

  invert_low_a: assert property ( // RL11
    @(posedge clk) disable iff (!resetn)
    (fire && gate_sel[4][0] == `CLGE_SRC_LO && gate_inv[4][0]) |=> gate_q[4])
    else $error("inverted low input did not raise or");

  shift_last_a: assert property ( // RL13
    @(posedge clk) disable iff (!resetn)
    (fire && net_out_sel[3] == (`CLGE_SRC_SHIFT_BASE + 8'h1f))
      |=> net_digital_out[3] == $past(shift_bits[31]))
    else $error("last shift bit not routed");

  cursor_base_a: assert property ( // RL15
    @(posedge clk) disable iff (!resetn)
    (fire && net_out_sel[4] == `CLGE_SRC_CURSOR_BASE && cursor_base[0])
      |=> net_digital_out[4])
    else $error("base cursor key lost");

  fkey_four_a: assert property ( // RL16
    @(posedge clk) disable iff (!resetn)
    (fire && net_out_sel[5] == (`CLGE_SRC_FKEY_BASE + 8'h03))
      |=> net_digital_out[5] == $past(operator_keys[3]))
    else $error("fourth operator key not routed");

  net_in_route_a: assert property ( // RL14
    @(posedge clk) disable iff (!resetn)
    (fire && net_out_sel[6] == `CLGE_SRC_NET_IN_BASE)
      |=> net_digital_out[6] == $past(net_digital_in[0]))
    else $error("network input not routed");

  gate_feedback_a: assert property ( // RL14
    @(posedge clk) disable iff (!resetn)
    (fire && net_out_sel[7] == `CLGE_SRC_GATE_BASE)
      |=> net_digital_out[7] == $past(gate_q[0]))
    else $error("gate result not routed to network output");

  analog_last_a: assert property ( // RL14
    @(posedge clk) disable iff (!resetn)
    fire |=> net_analog_out[15] == $past(net_analog_in[net_aout_sel[15]]))
    else $error("last analog output routing wrong");

  reset_clear_a: assert property ( // RL17
    @(posedge clk)
    !resetn |=> gate_q == '0 && net_digital_out == '0 && net_analog_out == '0)
    else $error("reset did not clear");
endmodule

// ===== hdl/clge_map.svh
// constants of the cycle logic gate evaluator: source pool layout, sizes, reset values
// assumes it is included by the package and directly by every design file, the guard keeping repeats harmless
// What this block does
// RL1 - and output high only if all high
// RL2 - open and/nand inputs read as one
// RL3 - rising and: all high now, one low before
// RL4 - nand output low only if all high
// RL5 - falling nand: one low now, all high before
// RL6 - or output high if any input high
// RL7 - nor output high only if all low
// RL8 - open or/nor/xor inputs read as zero
// RL9 - xor high when its two inputs differ
// RL10 - not outputs complement of its input
// RL11 - every gate input individually invertible
// RL12 - inputs may be tied constant high or low
// RL13 - shift bits readable, never written by gates
// RL14 - network pool: 64/32 in, 64/16 out
// RL15 - four cursor keys, remote equals base
// RL16 - four operator keys usable as inputs
// RL17 - edge gates keep previous inputs, reset zero
`ifndef CLGE_MAP_SVH
`define CLGE_MAP_SVH

`define CLGE_GATE_N 8
`define CLGE_GATE_INPUTS 4
`define CLGE_SEL_W 8
`define CLGE_POOL_N 256

`define CLGE_SRC_LO 8'h00
`define CLGE_SRC_HI 8'h01
`define CLGE_SRC_OPEN 8'h02
`define CLGE_SRC_SHIFT_BASE 8'h08
`define CLGE_SHIFT_N 32
`define CLGE_SRC_CURSOR_BASE 8'h28
`define CLGE_CURSOR_N 4
`define CLGE_SRC_FKEY_BASE 8'h2c
`define CLGE_FKEY_N 4
`define CLGE_SRC_NET_IN_BASE 8'h40
`define CLGE_NET_IN_N 64
`define CLGE_SRC_GATE_BASE 8'h80

`define CLGE_NET_OUT_N 64
`define CLGE_NET_AIN_N 32
`define CLGE_NET_AOUT_N 16
`define CLGE_ANALOG_W 16
`define CLGE_AIN_SEL_W 5

`define CLGE_PREV_RESET 4'h0
`define CLGE_Q_RESET 1'b0

`endif

// ===== hdl/clge_pkg.sv
// types shared by the gate evaluator files
// assumes clge_map.svh is on the include path
`include "clge_map.svh"
package clge_pkg;
  typedef enum {CLGE_AND, CLGE_AND_RISE, CLGE_NAND, CLGE_NAND_FALL,
                CLGE_OR, CLGE_NOR, CLGE_XOR, CLGE_NOT} clge_kind_t;
  typedef logic [`CLGE_SEL_W-1:0] clge_sel_t;
  typedef logic [`CLGE_ANALOG_W-1:0] clge_word_t;
endpackage

// ===== hdl/clge_gate_if.sv
// input bundle between a source selector and one gate
// assumes the top drives sel and inv from its configuration ports
`timescale 1ns/1ps
`include "clge_map.svh"
interface clge_gate_if;
  import clge_pkg::*;
  clge_sel_t [`CLGE_GATE_INPUTS-1:0] sel;
  logic [`CLGE_GATE_INPUTS-1:0] inv;
  logic [`CLGE_GATE_INPUTS-1:0] level;
  logic [`CLGE_GATE_INPUTS-1:0] open;
  modport mux (input sel, input inv, output level, output open);
  modport gate (input level, input open);
endinterface

// ===== hdl/clge_source_mux.sv
// picks each gate input from the source pool and applies its inversion
// assumes pool bit 0 is low, bit 1 high, and the open code is flagged apart
`timescale 1ns/1ps
`include "clge_map.svh"
module clge_source_mux
  import clge_pkg::*;
(
  // source pool
  input wire logic [`CLGE_POOL_N-1:0] pool,
  // gate side
  clge_gate_if.mux bus
);
  genvar i;
  generate
    for (i = 0; i < `CLGE_GATE_INPUTS; i++)
    begin : g_in
      // RL11 RL12 inversion and constant ties
      assign bus.level[i] = pool[bus.sel[i]] ^ bus.inv[i];
      assign bus.open[i] = (bus.sel[i] == `CLGE_SRC_OPEN);
    end
  endgenerate
endmodule

// ===== hdl/clge_gate.sv
// one basic gate evaluated once per program cycle strobe
// assumes inputs are stable in the strobe cycle; result stands until the next strobe
`timescale 1ns/1ps
`include "clge_map.svh"
module clge_gate
  import clge_pkg::*;
#(
  parameter clge_kind_t KIND = CLGE_AND
)
(
  // clock, reset, enable and strobe
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic strobe,
  // selected inputs
  clge_gate_if.gate bus,
  // result
  output logic q
);
  logic dflt;
  logic [`CLGE_GATE_INPUTS-1:0] eff;
  logic [`CLGE_GATE_INPUTS-1:0] prev_reg;
  logic [`CLGE_GATE_INPUTS-1:0] prev_next;
  logic q_reg;
  logic q_next;

  // RL2 RL8 open input defaults
  assign dflt = (KIND == CLGE_AND) || (KIND == CLGE_AND_RISE) ||
                (KIND == CLGE_NAND) || (KIND == CLGE_NAND_FALL);
  assign eff = (bus.open & {`CLGE_GATE_INPUTS{dflt}}) | (~bus.open & bus.level);

  always_comb
  begin
    prev_next = prev_reg;
    q_next = q_reg;
    if (strobe)
    begin
      // RL17 previous levels for edge forms
      prev_next = eff;
      case (KIND)
        // RL1 four input and
        CLGE_AND: q_next = &eff;
        // RL3 rising edge and
        CLGE_AND_RISE: q_next = (&eff) & ~(&prev_reg);
        // RL4 four input nand
        CLGE_NAND: q_next = ~(&eff);
        // RL5 falling edge nand
        CLGE_NAND_FALL: q_next = ~(&eff) & (&prev_reg);
        // RL6 four input or
        CLGE_OR: q_next = |eff;
        // RL7 four input nor
        CLGE_NOR: q_next = ~(|eff);
        // RL9 two input xor
        CLGE_XOR: q_next = eff[0] ^ eff[1];
        // RL10 single inverter
        CLGE_NOT: q_next = ~eff[0];
        default: q_next = `CLGE_Q_RESET;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      prev_reg <= `CLGE_PREV_RESET;
      q_reg <= `CLGE_Q_RESET;
    end
    else if (ce)
    begin
      prev_reg <= prev_next;
      q_reg <= q_next;
    end
  end

  assign q = q_reg;
endmodule

// ===== tb/testbench.sv
// self-checking bench of the gate evaluator: random and directed program cycles
// assumes clge_map.svh on the include path and clge_pkg compiled first
`timescale 1ns/1ps
`include "clge_map.svh"
`define check_eq(nm, ex, got) \
  begin \
    samples_checked++; \
    if ((got) !== (ex)) \
    begin \
      mismatches++; \
      $display("unexpected %s: expected %h seen %h", nm, ex, got); \
    end \
  end
module testbench
  import clge_pkg::*;
();
  typedef struct packed {logic [7:0] q; logic [63:0] nd; clge_word_t [15:0] na;} clge_exp_t;
  // clock, reset, strobe
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b0;
  logic cycle_strobe = 1'b0;
  // sources
  logic [31:0] shift_bits = '0;
  logic [3:0] cursor_base = '0;
  logic [3:0] cursor_remote = '0;
  logic [3:0] operator_keys = '0;
  logic [63:0] net_digital_in = '0;
  clge_word_t [31:0] net_analog_in = '0;
  // configuration
  clge_sel_t [7:0][3:0] gate_sel = '0;
  logic [7:0][3:0] gate_inv = '0;
  clge_sel_t [63:0] net_out_sel = '0;
  logic [15:0][4:0] net_aout_sel = '0;
  // results
  logic [7:0] gate_q;
  logic [63:0] net_digital_out;
  clge_word_t [15:0] net_analog_out;
  // model state and bookkeeping
  logic [31:0] lfsr = 32'h9eb4;
  logic [7:0] m_q;
  logic [7:0][3:0] m_prev;
  logic [63:0] m_nd;
  clge_word_t [15:0] m_na;
  clge_exp_t exp_q[$];
  clge_exp_t got_e;
  int mismatches = 0;
  int samples_checked = 0;

  clge_top i_dut (.clk(clk), .resetn(resetn), .ce(ce), .cycle_strobe(cycle_strobe),
    .shift_bits(shift_bits), .cursor_base(cursor_base), .cursor_remote(cursor_remote),
    .operator_keys(operator_keys), .net_digital_in(net_digital_in),
    .net_analog_in(net_analog_in), .gate_sel(gate_sel), .gate_inv(gate_inv),
    .net_out_sel(net_out_sel), .net_aout_sel(net_aout_sel), .gate_q(gate_q),
    .net_digital_out(net_digital_out), .net_analog_out(net_analog_out));

  always #50 clk = ~clk;

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  // every source kind, plus open and an unmapped code for outputs
  function automatic clge_sel_t rnd_code(input logic [31:0] r, input logic nout);
    case (r[2:0])
      3'h0: return 8'h00;
      3'h1: return 8'h01;
      3'h2: return nout ? 8'h03 : 8'h02;
      3'h3: return 8'h08 + 8'(r[8:4]);
      3'h4: return 8'h28 + 8'(r[5:4]);
      3'h5: return 8'h2c + 8'(r[5:4]);
      3'h6: return 8'h40 + 8'(r[9:4]);
      default: return 8'h80 + 8'(r[6:4]);
    endcase
  endfunction

  function automatic logic lvl(input clge_sel_t c);
    logic [3:0] cur;
    cur = cursor_base | cursor_remote;
    if (c == 8'h01) return 1'b1;
    if (c >= 8'h08 && c < 8'h28) return shift_bits[c - 8'h08];
    if (c >= 8'h28 && c < 8'h2c) return cur[c - 8'h28];
    if (c >= 8'h2c && c < 8'h30) return operator_keys[c - 8'h2c];
    if (c >= 8'h40 && c < 8'h80) return net_digital_in[c - 8'h40];
    if (c >= 8'h80 && c < 8'h88) return m_q[c - 8'h80];
    return 1'b0;
  endfunction

  task automatic model_eval();
    logic [3:0] e;
    logic [7:0] nq;
    for (int k = 0; k < 64; k++) m_nd[k] = lvl(net_out_sel[k]);
    for (int k = 0; k < 16; k++) m_na[k] = net_analog_in[net_aout_sel[k]];
    for (int g = 0; g < 8; g++)
    begin
      for (int i = 0; i < 4; i++)
        e[i] = (gate_sel[g][i] == 8'h02) ? (g < 4) : (lvl(gate_sel[g][i]) ^ gate_inv[g][i]);
      case (g)
        0: nq[g] = &e;
        1: nq[g] = (&e) & ~(&m_prev[g]);
        2: nq[g] = ~(&e);
        3: nq[g] = ~(&e) & (&m_prev[g]);
        4: nq[g] = |e;
        5: nq[g] = ~(|e);
        6: nq[g] = e[0] ^ e[1];
        default: nq[g] = ~e[0];
      endcase
      m_prev[g] = e;
    end
    m_q = nq;
  endtask

  // one cycle of stimulus; mode 1 ties every gate input to v[i], mode 2 leaves all open
  task automatic step(input logic [1:0] mode, input logic [3:0] v);
    logic [31:0] r;
    @(posedge clk);
    r = rnd();
    for (int g = 0; g < 8; g++)
      for (int i = 0; i < 4; i++)
        gate_sel[g][i] <= (mode == 2'h2) ? 8'h02 :
                          mode[0] ? {7'h00, v[i]} : rnd_code(rnd(), 1'b0);
    gate_inv <= mode[0] ? 32'h0 : rnd();
    for (int k = 0; k < 64; k++) net_out_sel[k] <= rnd_code(rnd(), 1'b1);
    for (int k = 0; k < 32; k++) net_analog_in[k] <= rnd() >> 3;
    for (int k = 0; k < 16; k++) net_aout_sel[k] <= rnd() >> 7;
    shift_bits <= rnd();
    net_digital_in <= {rnd(), rnd()};
    cursor_base <= r[3:0];
    cursor_remote <= r[7:4];
    operator_keys <= r[11:8];
    ce <= (mode != 2'h0) || (r[14:12] != 3'h0);
    cycle_strobe <= (mode != 2'h0) || (r[17:15] != 3'h0);
    #1;
    if (cycle_strobe === 1'b1)
    begin
      if (ce === 1'b1) model_eval();
      exp_q.push_back({m_q, m_nd, m_na});
    end
  endtask

  task automatic do_reset(input int n);
    @(posedge clk);
    resetn <= 1'b0;
    cycle_strobe <= 1'b0;
    repeat (n) @(posedge clk);
    resetn <= 1'b1;
    m_q = '0;
    m_prev = '0;
    m_nd = '0;
    m_na = '0;
    #1;
    `check_eq("gate_q", 8'h00, gate_q)
    `check_eq("net_digital_out", 64'h0, net_digital_out)
  endtask

  // result after every strobe, taken or refused
  always @(posedge clk)
    if (resetn === 1'b1 && cycle_strobe === 1'b1)
    begin
      #1;
      if (exp_q.size() == 0)
      begin
        mismatches++;
        $display("unexpected strobe: expected none seen one");
      end
      else
      begin
        got_e = exp_q.pop_front();
        `check_eq("gate_q", got_e.q, gate_q)
        `check_eq("net_digital_out", got_e.nd, net_digital_out)
        `check_eq("net_analog_out", got_e.na, net_analog_out)
      end
    end

  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (30000) @(posedge clk);
    mismatches++;
    results();
  end

  initial
  begin
    do_reset(20);
    // first strobe after reset sees previous inputs as zero
    step(1'b1, 4'hf);
    // full truth tables twice, so edges rise and fall
    for (int p = 0; p < 2; p++)
      for (int v = 0; v < 16; v++) step(1'b1, 4'(v));
    step(2'h1, 4'h0);
    // every input open, with random inversions that must not reach them
    repeat (3) step(2'h2, 4'h0);
    repeat (600) step(2'h0, 4'h0);
    do_reset(2);
    step(1'b1, 4'hf);
    step(1'b1, 4'h7);
    repeat (300) step(1'b0, 4'h0);
    @(posedge clk);
    cycle_strobe <= 1'b0;
    repeat (3) @(posedge clk);
    `check_eq("pending results", 0, exp_q.size())
    results();
  end
endmodule
